// ===== design/core_irq_cfg.svh
/*
  Offsets, bit positions, reset values and fixed codes of the core interrupt unit.
  Assumes inclusion by bare name from the design files; definitions only.
*/
`ifndef CORE_IRQ_CFG_SVH
`define CORE_IRQ_CFG_SVH

// register byte offsets on the register bus
`define IRQ_OFF_CONTROL   8'h00
`define IRQ_OFF_PERIPH    8'h04
`define IRQ_OFF_EDGE      8'h08
`define IRQ_OFF_STATE     8'h0C
`define IRQ_OFF_SHADOW    8'h20
`define IRQ_SHADOW_MASK   8'hE0

// control register fields
`define IRQ_BIT_GIE       7
`define IRQ_BIT_PERIPHERAL_GROUP_ENABLE      6
`define IRQ_BIT_T0IE      5
`define IRQ_BIT_EXTIE     4
`define IRQ_BIT_PCIE      3
`define IRQ_BIT_T0IF      2
`define IRQ_BIT_EXTIF     1
`define IRQ_BIT_PCIF      0
`define IRQ_CTRL_WMASK    8'hFE
`define IRQ_CTRL_RESET    8'h00
`define IRQ_PERIPH_RESET  8'h00
`define IRQ_EDGE_RESET    1'b0

// sequencing
`define IRQ_VECTOR        15'h0004

// context layout: byte index within the shadow set
`define CTX_STATUS        3'h1
`define CTX_BSR           3'h2
`define CTX_PC_HIGH_LATCH        3'h7
`define CTX_STATUS_KEEP   8'hE7
`define CTX_BSR_KEEP      8'h1F
`define CTX_PC_HIGH_LATCH_KEEP   8'h7F
`define CTX_RESET         8'h00

// bus responses
`define AXI_OKAY          2'b00
`define AXI_SLVERR        2'b10

`endif

// ===== design/core_irq_pkg.sv
/*
  Types of the core interrupt unit: sequencer states and the context image.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package core_irq_pkg;

  typedef enum logic [2:0] {
    ST_RUN       = 3'b001,
    ST_WAKE_STEP = 3'b010,
    ST_ENTRY     = 3'b100
  } seq_state_type;

  // bytes: 0 w, 1 status, 2 bank_select, 3/4 indirect_pointer0 lo/hi,
  // 5/6 indirect_pointer1 lo/hi, 7 pc_high_latch
  typedef logic [7:0][7:0] ctx_type;

endpackage : core_irq_pkg
`default_nettype wire

// ===== design/core_irq_ctx_if.sv
/*
  Carrier between the interrupt sequencer and its shadow register store.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface core_irq_ctx_if;
  logic                  save;
  logic                  wr;
  logic [2:0]            idx;
  logic [7:0]            wdata;
  core_irq_pkg::ctx_type live;
  core_irq_pkg::ctx_type saved;

  modport ctrl  (output save, wr, idx, wdata, live, input saved);
  modport store (input save, wr, idx, wdata, live, output saved);
endinterface : core_irq_ctx_if
`default_nettype wire

// ===== design/core_irq_shadow.sv
/*
  Shadow register store: captures the live context on interrupt entry and
  accepts software writes to each shadow byte.
  Assumes save and wr are one-cycle strobes from the sequencer.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_irq_cfg.svh"
module core_irq_shadow (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  core_irq_ctx_if.store  ctx
);
  import core_irq_pkg::*;

  // unimplemented bits of each byte; status drops its timeout and sleep bits
  function automatic logic [7:0] keep_mask(input logic [2:0] idx);
    case (idx)
      `CTX_STATUS: keep_mask = `CTX_STATUS_KEEP;
      `CTX_BSR:    keep_mask = `CTX_BSR_KEEP;
      `CTX_PC_HIGH_LATCH: keep_mask = `CTX_PC_HIGH_LATCH_KEEP;
      default:     keep_mask = 8'hFF;
    endcase
  endfunction : keep_mask

  ctx_type saved;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      saved <= '0;
    end else if (ctx.save) begin
      for (int i = 0; i < 8; i++) begin
        saved[i] <= ctx.live[i] & keep_mask(3'(i));
      end
    end else if (ctx.wr) begin
      saved[ctx.idx] <= ctx.wdata & keep_mask(ctx.idx);
    end
  end

  assign ctx.saved = saved;
endmodule : core_irq_shadow
`default_nettype wire

// ===== design/core_interrupt_unit.sv
/*
  Core interrupt unit: flag capture, enable gating, wake from sleep, vector
  entry sequencing and context shadowing, with an AXI4-Lite register slave.
  Assumes the core sequencer gives one cycle_i strobe per instruction cycle,
  holds sleeping_i high while asleep and pulses return_from_isr_i on return_from_isr.
*/
`timescale 1ns/1ps
`default_nettype none
`include "core_irq_cfg.svh"

// Overview of operation
// - wake branches to vector only with global enable
// - instruction after sleep runs before vectoring
// - external pin edge interrupt gated by its enable
// - edge select: set rising, clear falling
// - selected edge sets external pin flag
// - external flag with both enables vectors
// - entry pushes return program counter
// - entry copies context into shadows, status masked
// - return restores context from shadows
// - shadows readable, writable, written value restored
// - flags set regardless of any enable
// - bit 7 global enable blocks all
// - bit 6 gates peripheral group sources
// - bits 5,4,3 timer0, pin, change enables
// - bit 2 timer0 overflow flag
// - bit 1 external flag sticky until cleared
// - bit 0 read-only pin-change summary
// - peripheral enable one bit layout
// - reset clears every interrupt enable
// - entry flushes, clears global, pushes, saves, vectors
// - return pops, restores, sets global enable
// - event to vector within two to five clocks
module core_interrupt_unit #(
  parameter int ADDR_W = 8
) (
  input  wire logic                  clk_i,
  input  wire logic                  sys_rst_i,
  // register bus
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr_i,
  input  wire logic                  s_axi_awvalid_i,
  output logic                       s_axi_awready_o,
  input  wire logic [31:0]           s_axi_wdata_i,
  input  wire logic [3:0]            s_axi_wstrb_i,
  input  wire logic                  s_axi_wvalid_i,
  output logic                       s_axi_wready_o,
  output logic [1:0]                 s_axi_bresp_o,
  output logic                       s_axi_bvalid_o,
  input  wire logic                  s_axi_bready_i,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr_i,
  input  wire logic                  s_axi_arvalid_i,
  output logic                       s_axi_arready_o,
  output logic [31:0]                s_axi_rdata_o,
  output logic [1:0]                 s_axi_rresp_o,
  output logic                       s_axi_rvalid_o,
  input  wire logic                  s_axi_rready_i,
  // interrupt sources
  input  wire logic                  timer0_overflow_i,
  input  wire logic                  ext_pin_i,
  input  wire logic [7:0]            port_b_change_flags_i,
  input  wire logic [7:0]            periph_flags_i,
  // core sequencer
  input  wire logic                  cycle_i,
  input  wire logic                  sleeping_i,
  input  wire logic                  return_from_isr_i,
  input  wire logic [14:0]           pc_i,
  input  wire core_irq_pkg::ctx_type ctx_live_i,
  output logic                       wake_o,
  output logic                       irq_req_o,
  output logic                       flush_o,
  output logic                       push_o,
  output logic [14:0]                push_pc_o,
  output logic                       pc_load_o,
  output logic [14:0]                vector_o,
  output logic                       restore_o,
  output core_irq_pkg::ctx_type      ctx_restore_o
);
  import core_irq_pkg::*;
  localparam logic [7:0] CTRL_RESET = `IRQ_CTRL_RESET;

  function automatic logic is_shadow(input logic [ADDR_W-1:0] addr);
    is_shadow = (8'(addr) & `IRQ_SHADOW_MASK) == `IRQ_OFF_SHADOW;
  endfunction : is_shadow

  function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
    logic [7:0] a;
    a = 8'(addr);
    is_mapped = (a[1:0] == 2'b00) && (a == `IRQ_OFF_CONTROL || a == `IRQ_OFF_PERIPH ||
                a == `IRQ_OFF_EDGE || a == `IRQ_OFF_STATE || is_shadow(addr));
  endfunction : is_mapped

  core_irq_ctx_if ctx ();

  core_irq_shadow u_shadow (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .ctx       (ctx.store)
  );

  logic [7:0]    control;
  logic [7:3]    ctrl_enables;
  logic          t0_flag;
  logic          ext_flag;
  logic          change_sum;
  logic [7:0]    peripheral_enable_one;
  logic          ext_edge_select;
  logic          ext_prev;
  logic          in_service;
  seq_state_type state;
  seq_state_type next_state;

  logic          wr_fire;
  logic          wr_lane0;
  logic [7:0]    wr_off;
  logic          rd_fire;
  logic [7:0]    rd_off;
  logic          ext_edge;
  logic          pend_core;
  logic          pend_periph;
  logic          pending;
  logic          irq_req;
  logic          take;
  logic          ctrl_wr;

  // ---------------- register bus ----------------
  // address and data are taken together, once the previous response is gone
  assign wr_fire         = s_axi_awvalid_i & s_axi_wvalid_i & ~s_axi_bvalid_o;
  assign s_axi_awready_o = wr_fire;
  assign s_axi_wready_o  = wr_fire;
  assign wr_lane0        = wr_fire & s_axi_wstrb_i[0];
  assign wr_off          = 8'(s_axi_awaddr_i);
  assign rd_fire         = s_axi_arvalid_i & ~s_axi_rvalid_o;
  assign s_axi_arready_o = rd_fire;
  assign rd_off          = 8'(s_axi_araddr_i);
  assign ctrl_wr         = wr_lane0 && wr_off == `IRQ_OFF_CONTROL;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= `AXI_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= is_mapped(s_axi_awaddr_i) ? `AXI_OKAY : `AXI_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= `AXI_OKAY;
      s_axi_rdata_o  <= 32'h0000_0000;
    end else if (rd_fire) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rresp_o  <= is_mapped(s_axi_araddr_i) ? `AXI_OKAY : `AXI_SLVERR;
      if (is_mapped(s_axi_araddr_i) && is_shadow(s_axi_araddr_i)) begin
        s_axi_rdata_o <= {24'h00_0000, ctx.saved[rd_off[4:2]]};
      end else begin
        case (rd_off)
          `IRQ_OFF_CONTROL: s_axi_rdata_o <= {24'h00_0000, control};
          `IRQ_OFF_PERIPH:  s_axi_rdata_o <= {24'h00_0000, peripheral_enable_one};
          `IRQ_OFF_EDGE:    s_axi_rdata_o <= {31'h0000_0000, ext_edge_select};
          `IRQ_OFF_STATE:   s_axi_rdata_o <= {27'h000_0000, state, in_service, irq_req};
          default:          s_axi_rdata_o <= 32'h0000_0000;
        endcase
      end
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end

  // ---------------- enables ----------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      peripheral_enable_one <= `IRQ_PERIPH_RESET;
    end else if (wr_lane0 && wr_off == `IRQ_OFF_PERIPH) begin
      peripheral_enable_one <= s_axi_wdata_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_edge_select <= `IRQ_EDGE_RESET;
    end else if (wr_lane0 && wr_off == `IRQ_OFF_EDGE) begin
      ext_edge_select <= s_axi_wdata_i[0];
    end
  end

  // writable control bits 7..1; hardware entry/return override the global bit
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_enables <= CTRL_RESET[`IRQ_BIT_GIE:`IRQ_BIT_PCIE];
    end else begin
      if (ctrl_wr) begin
        ctrl_enables <= s_axi_wdata_i[`IRQ_BIT_GIE:`IRQ_BIT_PCIE];
      end
      if (state == ST_ENTRY) begin
        ctrl_enables[`IRQ_BIT_GIE] <= 1'b0;
      end else if (return_from_isr_i) begin
        ctrl_enables[`IRQ_BIT_GIE] <= 1'b1;
      end
    end
  end

  // ---------------- flags ----------------
  // synchronous pin: one stage of history gives the edge
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_prev <= 1'b0;
    end else begin
      ext_prev <= ext_pin_i;
    end
  end

  assign ext_edge = ext_edge_select ? (ext_pin_i & ~ext_prev) : (~ext_pin_i & ext_prev);

  // a set in the same cycle as a software clear wins
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      t0_flag <= CTRL_RESET[`IRQ_BIT_T0IF];
    end else if (timer0_overflow_i) begin
      t0_flag <= 1'b1;
    end else if (ctrl_wr) begin
      t0_flag <= s_axi_wdata_i[`IRQ_BIT_T0IF];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ext_flag <= CTRL_RESET[`IRQ_BIT_EXTIF];
    end else if (ext_edge) begin
      ext_flag <= 1'b1;
    end else if (ctrl_wr) begin
      ext_flag <= s_axi_wdata_i[`IRQ_BIT_EXTIF];
    end
  end

  // summary follows the change flags; writes do not touch it
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      change_sum <= CTRL_RESET[`IRQ_BIT_PCIF];
    end else begin
      change_sum <= |port_b_change_flags_i;
    end
  end

  assign control = {ctrl_enables, t0_flag, ext_flag, change_sum};

  // ---------------- request ----------------
  assign pend_core = (control[`IRQ_BIT_T0IE]  & control[`IRQ_BIT_T0IF])  |
                     (control[`IRQ_BIT_EXTIE] & control[`IRQ_BIT_EXTIF]) |
                     (control[`IRQ_BIT_PCIE]  & control[`IRQ_BIT_PCIF]);
  assign pend_periph = control[`IRQ_BIT_PERIPHERAL_GROUP_ENABLE] & |(peripheral_enable_one & periph_flags_i);
  assign pending     = pend_core | pend_periph;
  assign irq_req     = control[`IRQ_BIT_GIE] & pending;
  assign irq_req_o   = irq_req;

  // wake needs only the source's own enables, not the global one
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wake_o <= 1'b0;
    end else begin
      wake_o <= sleeping_i & pending;
    end
  end

  // ---------------- sequencer ----------------
  assign take = irq_req & cycle_i & ~sleeping_i;

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (sleeping_i && pending) begin
          next_state = ST_WAKE_STEP;
        end else if (take) begin
          next_state = ST_ENTRY;
        end
      end
      ST_WAKE_STEP: begin
        // the instruction after sleep completes at the first strobe awake
        if (cycle_i && !sleeping_i) begin
          next_state = irq_req ? ST_ENTRY : ST_RUN;
        end
      end
      ST_ENTRY: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      push_pc_o <= 15'h0000;
    end else if (next_state == ST_ENTRY && state != ST_ENTRY) begin
      push_pc_o <= pc_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      in_service <= 1'b0;
    end else if (state == ST_ENTRY) begin
      in_service <= 1'b1;
    end else if (return_from_isr_i) begin
      in_service <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      restore_o <= 1'b0;
    end else begin
      restore_o <= return_from_isr_i;
    end
  end

  assign flush_o       = state == ST_ENTRY;
  assign push_o        = state == ST_ENTRY;
  assign pc_load_o     = state == ST_ENTRY;
  assign vector_o      = `IRQ_VECTOR;
  assign ctx_restore_o = ctx.saved;

  // shadow store access: capture on entry, software bytes otherwise
  assign ctx.save  = state == ST_ENTRY;
  assign ctx.wr    = wr_lane0 & is_mapped(s_axi_awaddr_i) & is_shadow(s_axi_awaddr_i);
  assign ctx.idx   = wr_off[4:2];
  assign ctx.wdata = s_axi_wdata_i[7:0];
  assign ctx.live  = ctx_live_i;

endmodule : core_interrupt_unit
`default_nettype wire

// ===== tb/core_interrupt_unit_chk.sv
/* checker of the core interrupt unit sequencing ports
   assumes it is bound into core_interrupt_unit */
`timescale 1ns/1ps
`default_nettype none
module core_interrupt_unit_chk (
  input wire logic                  clk_i,
  input wire logic                  sys_rst_i,
  input wire logic                  cycle_i,
  input wire logic                  sleeping_i,
  input wire logic                  return_from_isr_i,
  input wire logic [14:0]           pc_i,
  input wire core_irq_pkg::ctx_type ctx_live_i,
  input wire logic                  wake_o,
  input wire logic                  irq_req_o,
  input wire logic                  flush_o,
  input wire logic                  push_o,
  input wire logic [14:0]           push_pc_o,
  input wire logic                  pc_load_o,
  input wire logic [14:0]           vector_o,
  input wire logic                  restore_o,
  input wire core_irq_pkg::ctx_type ctx_restore_o
);
  import core_irq_pkg::*;
  localparam logic [63:0] KEEP = 64'h7FFF_FFFF_FF1F_E7FF;
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_entry_cause: assert property (flush_o |-> $past(irq_req_o && cycle_i && !sleeping_i))
    else $error("entry without a taken request");
  a_entry_take: assert property (irq_req_o && cycle_i && !sleeping_i && !flush_o |=> flush_o)
    else $error("taken request did not enter");
  a_entry_set: assert property (flush_o |-> push_o && pc_load_o && vector_o == 15'h0004)
    else $error("entry pulses or vector wrong");
  a_entry_once: assert property (flush_o |=> !flush_o && !irq_req_o)
    else $error("global enable not cleared on entry");
  a_push_pc: assert property (push_o |-> push_pc_o == $past(pc_i))
    else $error("pushed pc differs");
  a_shadow_save: assert property (flush_o |=> ctx_restore_o == ($past(ctx_live_i) & KEEP))
    else $error("shadow capture wrong");
  a_restore_step: assert property (restore_o == $past(return_from_isr_i))
    else $error("restore pulse misplaced");
  a_wake_cause: assert property (wake_o |-> $past(sleeping_i))
    else $error("wake while awake");
  a_asleep_hold: assert property (sleeping_i |=> !flush_o)
    else $error("entry while asleep");
endmodule : core_interrupt_unit_chk
bind core_interrupt_unit core_interrupt_unit_chk u_chk (.*);
`default_nettype wire

// ===== tb/core_seq_model.sv
/* core sequencer model: instruction strobe every four clocks, pc, live context,
   sleep and return; assumes the unit's clock and reset */
`timescale 1ns/1ps
`default_nettype none
module core_seq_model (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             sleep_req_i,
  input  wire logic             ret_req_i,
  input  wire logic             wake_i,
  input  wire logic             pc_load_i,
  input  wire logic [14:0]      vector_i,
  output logic                  cycle_o,
  output logic                  sleeping_o,
  output logic                  return_from_isr_o,
  output logic [14:0]           pc_o,
  output core_irq_pkg::ctx_type ctx_o
);
  import core_irq_pkg::*;
  logic [1:0] phase;
  assign cycle_o = phase == 2'h3;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      phase      <= 2'h0;
      sleeping_o <= 1'b0;
      return_from_isr_o   <= 1'b0;
      pc_o       <= 15'h0000;
      ctx_o      <= '0;
    end else begin
      phase    <= phase + 2'h1;
      return_from_isr_o <= cycle_o && ret_req_i;
      if (wake_i) begin
        sleeping_o <= 1'b0;
      end else if (cycle_o && sleep_req_i) begin
        sleeping_o <= 1'b1;
      end
      if (pc_load_i) begin
        pc_o <= vector_i;
      end else if (cycle_o && !sleeping_o) begin
        pc_o  <= pc_o + 15'h1;
        ctx_o <= {ctx_o[55:0], pc_o[7:0] ^ 8'hA5};
      end
    end
  end
endmodule : core_seq_model
`default_nettype wire

// ===== tb/tb_core_interrupt_unit.sv
/* testbench of the core interrupt unit: register bus master, source stimulus
   and core model; assumes design, checker and model are compiled first */
`timescale 1ns/1ps
`default_nettype none
`include "core_irq_cfg.svh"
module tb_core_interrupt_unit;
  import core_irq_pkg::*;
  logic        clk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [7:0]  s_axi_awaddr_i = 8'h00;
  logic [7:0]  s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic        s_axi_awvalid_i = 1'b0;
  logic        s_axi_wvalid_i = 1'b0;
  logic        s_axi_bready_i = 1'b0;
  logic        s_axi_arvalid_i = 1'b0;
  logic        s_axi_rready_i = 1'b0;
  logic        timer0_overflow_i = 1'b0;
  logic        ext_pin_i = 1'b0;
  logic [7:0]  port_b_change_flags_i = 8'h00;
  logic [7:0]  periph_flags_i = 8'h00;
  logic        sleep_req = 1'b0;
  logic        ret_req = 1'b0;
  logic        cycle_i, sleeping_i, return_from_isr_i, wake_o, irq_req_o, flush_o, push_o, pc_load_o;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
  logic        s_axi_rvalid_o, restore_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic [31:0] s_axi_rdata_o;
  logic [14:0] pc_i, push_pc_o, vector_o;
  ctx_type     ctx_live_i, ctx_restore_o;
  logic [31:0] seed = 32'h415A;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          n_entry = 0;
  int          lat;
  int          base;

  core_interrupt_unit dut (.*);
  core_seq_model model (.clk_i, .sys_rst_i, .sleep_req_i(sleep_req), .ret_req_i(ret_req),
    .wake_i(wake_o), .pc_load_i(pc_load_o), .vector_i(vector_o), .cycle_o(cycle_i),
    .sleeping_o(sleeping_i), .return_from_isr_o(return_from_isr_i), .pc_o(pc_i), .ctx_o(ctx_live_i));

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (flush_o) n_entry <= n_entry + 1;

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // control readback: bit 0 is the pin-change summary, never the written bit
  function automatic logic [31:0] ctl_exp(input logic [7:0] w, input logic s);
    return {24'h0, w[7:1], s};
  endfunction : ctl_exp

  function automatic logic [31:0] ext_exp(input logic pin, input logic sel);
    return (pin == sel) ? 32'h2 : 32'h0;
  endfunction : ext_exp

  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic axw(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'b1;
    s_axi_wvalid_i <= 1'b1;
    s_axi_bready_i <= 1'b1;
    do @(posedge clk_i); while (!s_axi_awready_o);
    s_axi_awvalid_i <= 1'b0;
    s_axi_wvalid_i <= 1'b0;
    do @(posedge clk_i); while (!s_axi_bvalid_o);
    s_axi_bready_i <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp_o});
  endtask : axw

  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge clk_i);
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'b1;
    s_axi_rready_i <= 1'b1;
    do @(posedge clk_i); while (!s_axi_arready_o);
    s_axi_arvalid_i <= 1'b0;
    do @(posedge clk_i); while (!s_axi_rvalid_o);
    s_axi_rready_i <= 1'b0;
    chk("rdata", e, s_axi_rdata_o);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp_o});
  endtask : axr

  task automatic ret_isr();
    ret_req <= 1'b1;
    do @(posedge clk_i); while (!return_from_isr_i);
    ret_req <= 1'b0;
  endtask : ret_isr

  task automatic nap();
    sleep_req <= 1'b1;
    do @(posedge clk_i); while (!sleeping_i);
    sleep_req <= 1'b0;
  endtask : nap

  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    close_out();
  end

  initial begin
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    axr(8'h00, 32'h0, `AXI_OKAY);
    axr(8'h04, 32'h0, `AXI_OKAY);
    axr(8'h08, 32'h0, `AXI_OKAY);
    axr(8'h0C, 32'h4, `AXI_OKAY);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      axw(8'h04, seed[7:0], `AXI_OKAY);
      axr(8'h04, {24'h0, seed[7:0]}, `AXI_OKAY);
      axw(8'h00, seed[15:8] & 8'h7F, `AXI_OKAY);
      chk("irq_req", 32'h0, {31'h0, irq_req_o});
      axr(8'h00, ctl_exp(seed[15:8] & 8'h7F, 1'b0), `AXI_OKAY);
    end
    s_axi_wstrb_i <= 4'hE;
    axw(8'h04, ~seed[7:0], `AXI_OKAY);
    s_axi_wstrb_i <= 4'hF;
    axr(8'h04, {24'h0, seed[7:0]}, `AXI_OKAY);
    axw(8'h10, 8'h5A, `AXI_SLVERR);
    axr(8'h02, 32'h0, `AXI_SLVERR);
    axw(8'h00, 8'h00, `AXI_OKAY);
    timer0_overflow_i <= 1'b1;
    @(posedge clk_i);
    timer0_overflow_i <= 1'b0;
    axr(8'h00, 32'h4, `AXI_OKAY);
    for (int e = 0; e < 2; e++) begin
      axw(8'h00, 8'h00, `AXI_OKAY);
      axw(8'h08, 8'(e), `AXI_OKAY);
      repeat (2) begin
        ext_pin_i <= ~ext_pin_i;
        repeat (3) @(posedge clk_i);
        axr(8'h00, ext_exp(ext_pin_i, e[0]), `AXI_OKAY);
        axw(8'h00, 8'h00, `AXI_OKAY);
      end
    end
    seed = xs(seed);
    port_b_change_flags_i <= seed[7:0] | 8'h01;
    axw(8'h00, 8'h00, `AXI_OKAY);
    axr(8'h00, 32'h1, `AXI_OKAY);
    port_b_change_flags_i <= 8'h00;
    axr(8'h00, 32'h0, `AXI_OKAY);
    axw(8'h04, 8'h01, `AXI_OKAY);
    periph_flags_i <= 8'h01;
    axw(8'h00, 8'h80, `AXI_OKAY);
    chk("irq_req", 32'h0, {31'h0, irq_req_o});
    axw(8'h00, 8'hC0, `AXI_OKAY);
    do @(posedge clk_i); while (!flush_o);
    periph_flags_i <= 8'h00;
    axr(8'h00, 32'h40, `AXI_OKAY);
    ret_isr();
    axr(8'h00, 32'hC0, `AXI_OKAY);
    axw(8'h08, 8'h01, `AXI_OKAY);
    axw(8'h00, 8'h90, `AXI_OKAY);
    ext_pin_i <= 1'b1;
    lat = 0;
    do begin
      @(posedge clk_i);
      lat++;
    end while (!flush_o);
    chk("latency", 32'h1, {31'h0, lat <= 8});
    axr(8'h00, 32'h12, `AXI_OKAY);
    seed = xs(seed);
    axw(8'h20, seed[7:0], `AXI_OKAY);
    axw(8'h21, ~seed[7:0], `AXI_SLVERR);
    axr(8'h20, {24'h0, seed[7:0]}, `AXI_OKAY);
    axr(8'h21, 32'h0, `AXI_SLVERR);
    axw(8'h24, 8'hFF, `AXI_OKAY);
    axr(8'h24, 32'hE7, `AXI_OKAY);
    axw(8'h00, 8'h10, `AXI_OKAY);
    ret_isr();
    @(posedge clk_i);
    chk("shadow_w", {24'h0, seed[7:0]}, {24'h0, ctx_restore_o[0]});
    axr(8'h00, 32'h90, `AXI_OKAY);
    ext_pin_i <= 1'b0;
    for (int g = 0; g < 2; g++) begin
      axw(8'h00, g ? 8'h90 : 8'h10, `AXI_OKAY);
      base = n_entry;
      nap();
      ext_pin_i <= 1'b1;
      do @(posedge clk_i); while (!wake_o);
      repeat (16) @(posedge clk_i);
      chk("entries", g, n_entry - base);
      ext_pin_i <= 1'b0;
      axw(8'h00, 8'h00, `AXI_OKAY);
      if (g) ret_isr();
    end
    close_out();
  end
endmodule : tb_core_interrupt_unit
`default_nettype wire
